// *** verilog/pmrcs_pkg.sv ***
// constants shared by the rail control and status register group
package pmrcs_pkg;

  // register offsets
  localparam logic [7:0] PMRCS_OFS_RAIL_ENABLE = 8'h08;
  localparam logic [7:0] PMRCS_OFS_DISCHARGE   = 8'h09;
  localparam logic [7:0] PMRCS_OFS_SENSE       = 8'h0a;
  localparam logic [7:0] PMRCS_OFS_ACK         = 8'h0b;

  // reset values
  localparam logic [7:0] PMRCS_RST_RAIL_ENABLE = 8'h80;
  localparam logic [7:0] PMRCS_RST_DISCHARGE   = 8'h3f;
  localparam logic [7:0] PMRCS_RST_SENSE       = 8'h04;
  localparam logic [7:0] PMRCS_RST_ACK         = 8'h00;

  // rail enable fields
  localparam int PMRCS_BIT_LEVEL_SEL = 7;
  localparam int PMRCS_BIT_BUCK_ON   = 5;
  localparam int PMRCS_LINREG_MSB    = 4;
  localparam int PMRCS_LINREG_LSB    = 0;

  // discharge and thermal recovery fields
  localparam int PMRCS_RECOV_MSB     = 7;
  localparam int PMRCS_RECOV_LSB     = 6;
  localparam int PMRCS_BIT_BUCK_DIS  = 5;

  // live sense / acknowledge bit positions
  localparam int PMRCS_BIT_UNDERVOLT = 3;
  localparam int PMRCS_BIT_PWRUP     = 2;
  localparam int PMRCS_BIT_TSD       = 1;
  localparam int PMRCS_BIT_WARN      = 0;
  localparam int PMRCS_FLAG_W        = 4;

  // buck level code width
  localparam int PMRCS_LEVEL_W       = 5;

  // timing: clock rate and power-up sequence length
  localparam int PMRCS_CLK_KHZ       = 125000;
  localparam int PMRCS_SLOT_US       = 128;
  localparam int PMRCS_SLOT_CYCLES   = (PMRCS_SLOT_US * PMRCS_CLK_KHZ + 999) / 1000;
  localparam int PMRCS_PWRUP_SLOTS   = 16;

  typedef enum logic [1:0] {
    PMRCS_RECOV_RESET_RESTART = 2'b00,
    PMRCS_RECOV_KEEP_RESTART  = 2'b01,
    PMRCS_RECOV_NONE          = 2'b10,
    PMRCS_RECOV_UNDEFINED     = 2'b11
  } pmrcs_recov_t;

  typedef enum logic [1:0] {
    PMRCS_TH_RUN,
    PMRCS_TH_SHUT,
    PMRCS_TH_LOCK
  } pmrcs_therm_state_t;

endpackage : pmrcs_pkg

// *** verilog/pmrcs_pwrup_timer.sv ***
// power-up sequence timer: counts slots of fixed length after a start pulse
module pmrcs_pwrup_timer
  import pmrcs_pkg::*;
#(
  parameter int SLOT_CYCLES = PMRCS_SLOT_CYCLES,
  parameter int SLOTS       = PMRCS_PWRUP_SLOTS
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  input  wire logic hold_i,
  output logic      busy_o
);

  localparam int CW = $clog2(SLOT_CYCLES + 1);
  localparam int SW = $clog2(SLOTS + 1);
  localparam logic [CW-1:0] CYC_LAST  = CW'(SLOT_CYCLES - 1);
  localparam logic [SW-1:0] SLOT_LAST = SW'(SLOTS - 1);

  logic [CW-1:0] cyc_reg;
  logic [CW-1:0] cyc_next;
  logic [SW-1:0] slot_reg;
  logic [SW-1:0] slot_next;
  logic          busy_reg;
  logic          busy_next;

  always_comb
  begin
    cyc_next  = cyc_reg;
    slot_next = slot_reg;
    busy_next = busy_reg;
    if (hold_i)
    begin
      // enable pin low or thermal stop: sequence abandoned
      busy_next = 1'b0;
      cyc_next  = '0;
      slot_next = '0;
    end
    else if (start_i)
    begin
      busy_next = 1'b1;
      cyc_next  = '0;
      slot_next = '0;
    end
    else if (busy_reg)
    begin
      if (cyc_reg == CYC_LAST)
      begin
        cyc_next = '0;
        if (slot_reg == SLOT_LAST)
        begin
          busy_next = 1'b0;
        end
        else
        begin
          slot_next = slot_reg + SW'(1);
        end
      end
      else
      begin
        cyc_next = cyc_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cyc_reg  <= '0;
      slot_reg <= '0;
      busy_reg <= 1'b0;
    end
    else
    begin
      cyc_reg  <= cyc_next;
      slot_reg <= slot_next;
      busy_reg <= busy_next;
    end
  end

  assign busy_o = busy_reg;

endmodule : pmrcs_pwrup_timer

// *** verilog/pmrcs_regs.sv ***
// rail control and live sense register group of the power-management device
//
// Functional notes
// - enable bit 7 picks buck level: 0 second stored code, 1 first code
// - enable bit 5 switches the buck converter on or off
// - enable bits 4..0 switch linear regulators five down to one
// - recovery code 10 means no restart after thermal shutdown; 11 undefined
// - recovery code 01 restarts power-up keeping register contents
// - recovery code 00 restores defaults then restarts power-up
// - discharge bit 5 enables buck output active discharge
// - discharge bits 4..0 enable discharge for linear regulators five..one
// - status bit 3 shows input undervoltage with hysteresis from the comparator
// - status bit 2 is 0 during power-up, 1 when done or enable pin low
// - status bit 1 shows die above thermal shutdown threshold
// - status bit 0 shows die above thermal warning threshold
// - undervoltage, shutdown, warning acknowledges latch on either flag edge
// - power-up acknowledge latches only on rising edge of its flag
// - power-up done rises sixteen 128 us slots after enable pin rises
module pmrcs_regs
  import pmrcs_pkg::*;
#(
  parameter int SLOT_CYCLES = PMRCS_SLOT_CYCLES,
  parameter int SLOTS       = PMRCS_PWRUP_SLOTS
) (
  input  wire logic                     clk_i,
  input  wire logic                     resetn_i,
  input  wire logic                     hw_enable_pin_i,
  input  wire logic                     undervolt_sense_i,
  input  wire logic                     overtemp_shutdown_sense_i,
  input  wire logic                     overtemp_warning_sense_i,
  input  wire logic [7:0]               reg_addr_i,
  input  wire logic                     reg_wr_i,
  input  wire logic [7:0]               reg_wdata_i,
  input  wire logic                     reg_rd_i,
  input  wire logic [PMRCS_LEVEL_W-1:0] buck_level_first_i,
  input  wire logic [PMRCS_LEVEL_W-1:0] buck_level_second_i,
  output logic [7:0]                    reg_rdata_o,
  output logic                          reg_rvalid_o,
  output logic                          buck_on_o,
  output logic [4:0]                    linreg_on_o,
  output logic [PMRCS_LEVEL_W-1:0]      buck_level_o,
  output logic                          buck_discharge_on_o,
  output logic [4:0]                    linreg_discharge_on_o,
  output logic                          thermal_halt_o
);

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // pin synchronisers: 0 enable pin, 1 undervolt, 2 shutdown, 3 warning
  localparam int NPIN = 4;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_reg;
  logic [NPIN-1:0] pin_sync_reg;
  logic            hw_enable_pin_prev_reg;

  assign pin_raw = {overtemp_warning_sense_i, overtemp_shutdown_sense_i,
                    undervolt_sense_i, hw_enable_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge clk_i or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
        begin
          pin_meta_reg[gi] <= 1'b0;
          pin_sync_reg[gi] <= 1'b0;
        end
        else
        begin
          pin_meta_reg[gi] <= pin_raw[gi];
          pin_sync_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  logic hw_enable_pin;
  logic hw_enable_pin_rise;
  assign hw_enable_pin      = pin_sync_reg[0];
  assign hw_enable_pin_rise = hw_enable_pin & ~hw_enable_pin_prev_reg;

  // thermal recovery and power-up control
  pmrcs_therm_state_t th_state_reg;
  pmrcs_therm_state_t th_state_next;
  logic               restore_defaults;
  logic               restart_pwrup;
  logic               pwrup_busy;
  logic [7:0]         rail_enable_reg;
  logic [7:0]         rail_enable_next;
  logic [7:0]         discharge_reg;
  logic [7:0]         discharge_next;
  logic [7:0]         sense_reg;
  logic [7:0]         sense_next;
  logic [7:0]         ack_reg;
  logic [7:0]         ack_next;
  logic [PMRCS_FLAG_W-1:0] flags;
  logic [PMRCS_FLAG_W-1:0] flag_rise;
  logic [PMRCS_FLAG_W-1:0] flag_fall;
  pmrcs_recov_t       policy;

  assign policy = pmrcs_recov_t'(discharge_reg[PMRCS_RECOV_MSB:PMRCS_RECOV_LSB]);

  always_comb
  begin
    th_state_next    = th_state_reg;
    restore_defaults = 1'b0;
    restart_pwrup    = 1'b0;
    case (th_state_reg)
      PMRCS_TH_RUN:
      begin
        if (flag_rise[PMRCS_BIT_TSD])
        begin
          th_state_next = PMRCS_TH_SHUT;
        end
      end
      PMRCS_TH_SHUT:
      begin
        if (flag_fall[PMRCS_BIT_TSD])
        begin
          case (policy)
            PMRCS_RECOV_RESET_RESTART:
            begin
              restore_defaults = 1'b1;
              restart_pwrup    = hw_enable_pin;
              th_state_next    = PMRCS_TH_RUN;
            end
            PMRCS_RECOV_KEEP_RESTART:
            begin
              restart_pwrup = hw_enable_pin;
              th_state_next = PMRCS_TH_RUN;
            end
            default:
            begin
              // undefined code handled as the safe no-restart case
              th_state_next = PMRCS_TH_LOCK;
            end
          endcase
        end
      end
      PMRCS_TH_LOCK:
      begin
        // only cycling the enable pin re-arms a locked device
        if (!hw_enable_pin)
        begin
          th_state_next = PMRCS_TH_RUN;
        end
      end
      default:
      begin
        th_state_next = PMRCS_TH_RUN;
      end
    endcase
  end

  pmrcs_pwrup_timer #(
    .SLOT_CYCLES (SLOT_CYCLES),
    .SLOTS       (SLOTS)
  ) u_pwrup_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_reg),
    .start_i (hw_enable_pin_rise | restart_pwrup),
    // next state, so the restart issued on the edge leaving shutdown is not held off
    .hold_i  (~hw_enable_pin | (th_state_next != PMRCS_TH_RUN)),
    .busy_o  (pwrup_busy)
  );

  // live flags and their edges
  always_comb
  begin
    flags                      = '0;
    flags[PMRCS_BIT_UNDERVOLT] = pin_sync_reg[1];
    flags[PMRCS_BIT_PWRUP]     = ~pwrup_busy | ~hw_enable_pin;
    flags[PMRCS_BIT_TSD]       = pin_sync_reg[2];
    flags[PMRCS_BIT_WARN]      = pin_sync_reg[3];
  end

  assign flag_rise = flags & ~sense_reg[PMRCS_FLAG_W-1:0];
  assign flag_fall = ~flags & sense_reg[PMRCS_FLAG_W-1:0];

  // register file
  logic       wr_rail;
  logic       wr_dis;
  logic       rd_ack;
  logic [7:0] rdata_next;
  logic [PMRCS_FLAG_W-1:0] ack_set;

  assign wr_rail = reg_wr_i & (reg_addr_i == PMRCS_OFS_RAIL_ENABLE);
  assign wr_dis  = reg_wr_i & (reg_addr_i == PMRCS_OFS_DISCHARGE);
  assign rd_ack  = reg_rd_i & (reg_addr_i == PMRCS_OFS_ACK);

  always_comb
  begin
    ack_set                      = flag_rise | flag_fall;
    ack_set[PMRCS_BIT_PWRUP]     = flag_rise[PMRCS_BIT_PWRUP];

    rail_enable_next = rail_enable_reg;
    discharge_next   = discharge_reg;
    if (restore_defaults)
    begin
      rail_enable_next = PMRCS_RST_RAIL_ENABLE;
      discharge_next   = PMRCS_RST_DISCHARGE;
    end
    else
    begin
      if (wr_rail)
      begin
        rail_enable_next = reg_wdata_i;
      end
      if (wr_dis)
      begin
        discharge_next = reg_wdata_i;
      end
    end

    // the sense register takes no writes
    sense_next = {4'h0, flags};

    // an edge landing on the clearing read survives it
    ack_next = ack_reg;
    if (rd_ack)
    begin
      ack_next = 8'h00;
    end
    ack_next[PMRCS_FLAG_W-1:0] = ack_next[PMRCS_FLAG_W-1:0] | ack_set;

    case (reg_addr_i)
      PMRCS_OFS_RAIL_ENABLE: rdata_next = rail_enable_reg;
      PMRCS_OFS_DISCHARGE:   rdata_next = discharge_reg;
      PMRCS_OFS_SENSE:       rdata_next = sense_reg;
      PMRCS_OFS_ACK:         rdata_next = {4'h0, ack_reg[PMRCS_FLAG_W-1:0]};
      default:               rdata_next = 8'h00;
    endcase
    if (!reg_rd_i)
    begin
      rdata_next = reg_rdata_o;
    end
  end

  // rail outputs, gated off while the thermal controller holds the device down
  logic                     run_ok;
  logic                     buck_on_next;
  logic [4:0]               linreg_on_next;
  logic [PMRCS_LEVEL_W-1:0] level_next;

  assign run_ok = hw_enable_pin & (th_state_next == PMRCS_TH_RUN);

  always_comb
  begin
    buck_on_next   = run_ok & rail_enable_next[PMRCS_BIT_BUCK_ON];
    linreg_on_next = {5{run_ok}} &
                     rail_enable_next[PMRCS_LINREG_MSB:PMRCS_LINREG_LSB];
    if (rail_enable_next[PMRCS_BIT_LEVEL_SEL])
    begin
      level_next = buck_level_first_i;
    end
    else
    begin
      level_next = buck_level_second_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      th_state_reg          <= PMRCS_TH_RUN;
      hw_enable_pin_prev_reg         <= 1'b0;
      rail_enable_reg       <= PMRCS_RST_RAIL_ENABLE;
      discharge_reg         <= PMRCS_RST_DISCHARGE;
      sense_reg             <= PMRCS_RST_SENSE;
      ack_reg               <= PMRCS_RST_ACK;
      reg_rdata_o           <= 8'h00;
      reg_rvalid_o          <= 1'b0;
      buck_on_o             <= 1'b0;
      linreg_on_o           <= 5'h00;
      buck_level_o          <= '0;
      buck_discharge_on_o   <= 1'b0;
      linreg_discharge_on_o <= 5'h00;
      thermal_halt_o        <= 1'b0;
    end
    else
    begin
      th_state_reg          <= th_state_next;
      hw_enable_pin_prev_reg         <= hw_enable_pin;
      rail_enable_reg       <= rail_enable_next;
      discharge_reg         <= discharge_next;
      sense_reg             <= sense_next;
      ack_reg               <= ack_next;
      reg_rdata_o           <= rdata_next;
      reg_rvalid_o          <= reg_rd_i;
      buck_on_o             <= buck_on_next;
      linreg_on_o           <= linreg_on_next;
      buck_level_o          <= level_next;
      buck_discharge_on_o   <= discharge_next[PMRCS_BIT_BUCK_DIS];
      linreg_discharge_on_o <= discharge_next[PMRCS_LINREG_MSB:PMRCS_LINREG_LSB];
      thermal_halt_o        <= (th_state_next != PMRCS_TH_RUN);
    end
  end

endmodule : pmrcs_regs

// *** verif/pmrcs_regs_chk.sv ***
// assertion checker for the rail control and status register group
module pmrcs_regs_chk
  import pmrcs_pkg::*;
(
  input wire logic                     clk_i,
  input wire logic                     resetn_i,
  input wire logic                     hw_enable_pin_i,
  input wire logic                     overtemp_shutdown_sense_i,
  input wire logic [7:0]               reg_addr_i,
  input wire logic                     reg_wr_i,
  input wire logic [7:0]               reg_wdata_i,
  input wire logic                     reg_rd_i,
  input wire logic [PMRCS_LEVEL_W-1:0] buck_level_first_i,
  input wire logic [PMRCS_LEVEL_W-1:0] buck_level_second_i,
  input wire logic [7:0]               reg_rdata_o,
  input wire logic                     reg_rvalid_o,
  input wire logic                     buck_on_o,
  input wire logic [4:0]               linreg_on_o,
  input wire logic [PMRCS_LEVEL_W-1:0] buck_level_o,
  input wire logic                     buck_discharge_on_o,
  input wire logic [4:0]               linreg_discharge_on_o,
  input wire logic                     thermal_halt_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read got no answer");
  a_answer_idle: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("answer without a read");
  a_sense_upper: assert property (reg_rd_i && reg_addr_i == PMRCS_OFS_SENSE
    |=> reg_rdata_o[7:4] == 4'h0)
    else $error("status upper bits not zero");
  a_ack_upper: assert property (reg_rd_i && reg_addr_i == PMRCS_OFS_ACK
    |=> reg_rdata_o[7:4] == 4'h0)
    else $error("ack upper bits not zero");
  a_level_pick: assert property (reg_wr_i && reg_addr_i == PMRCS_OFS_RAIL_ENABLE |=> ##1
    buck_level_o == ($past(reg_wdata_i[7], 2) ? buck_level_first_i : buck_level_second_i))
    else $error("buck level does not follow select bit");
  a_dis_buck: assert property (reg_wr_i && reg_addr_i == PMRCS_OFS_DISCHARGE |=> ##1
    buck_discharge_on_o == $past(reg_wdata_i[5], 2))
    else $error("buck discharge does not follow write");
  a_dis_linreg: assert property (reg_wr_i && reg_addr_i == PMRCS_OFS_DISCHARGE |=> ##1
    linreg_discharge_on_o == $past(reg_wdata_i[4:0], 2))
    else $error("regulator discharge does not follow write");
  a_pin_off: assert property (!hw_enable_pin_i [*5]
    |-> !buck_on_o && linreg_on_o == 5'h00)
    else $error("rail on while enable pin low");
  a_tsd_halt: assert property (overtemp_shutdown_sense_i [*8]
    |-> thermal_halt_o && !buck_on_o)
    else $error("no halt in thermal shutdown");

  c_ack_read: cover property (reg_rvalid_o && reg_rdata_o[3:0] != 4'h0);
  c_halt: cover property (thermal_halt_o);
  c_buck_on: cover property (buck_on_o && linreg_on_o != 5'h00);
endmodule : pmrcs_regs_chk

bind pmrcs_regs pmrcs_regs_chk u_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .hw_enable_pin_i(hw_enable_pin_i),
  .overtemp_shutdown_sense_i(overtemp_shutdown_sense_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .buck_level_first_i(buck_level_first_i), .buck_level_second_i(buck_level_second_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .buck_on_o(buck_on_o),
  .linreg_on_o(linreg_on_o), .buck_level_o(buck_level_o),
  .buck_discharge_on_o(buck_discharge_on_o), .linreg_discharge_on_o(linreg_discharge_on_o),
  .thermal_halt_o(thermal_halt_o)
);

// *** verif/pmrcs_host_model.sv ***
// register port host: single reads and writes launched on the falling edge
module pmrcs_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i,
  output logic [7:0]      reg_addr_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_rd_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o    = 1'b0;
  end

  // idle address and data are inverted so a stale value is never mistaken for a request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge clk_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    d          = reg_rvalid_i ? reg_rdata_i : 8'hxx;
  endtask : rd
endmodule : pmrcs_host_model

// *** verif/tb_pmrcs_regs.sv ***
// self-checking bench for the rail control and status register group
module tb_pmrcs_regs
  import pmrcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOT_N  = 4;
  localparam int SLOT_K  = 16;
  localparam int PWR_CYC = SLOT_N * SLOT_K;
  localparam logic [4:0] LV1 = 5'h0a;
  localparam logic [4:0] LV2 = 5'h15;
  logic       clk_i    = 1'b0;
  logic       resetn_i = 1'b0;
  logic       pin = 1'b0, uv = 1'b0, tsd = 1'b0, warn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rail, dis;
  logic       reg_wr, reg_rd, reg_rvalid, buck_on, buck_dis, halt;
  logic [4:0] linreg_on, linreg_dis, level;
  int         miscompares = 0;
  int         checked     = 0;

  assign rail = {buck_on, 2'b00, linreg_on};
  assign dis  = {2'b00, buck_dis, linreg_dis};
  always #4 clk_i = ~clk_i;

  pmrcs_regs #(.SLOT_CYCLES(SLOT_N), .SLOTS(SLOT_K)) u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .hw_enable_pin_i(pin), .undervolt_sense_i(uv),
    .overtemp_shutdown_sense_i(tsd), .overtemp_warning_sense_i(warn),
    .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
    .buck_level_first_i(LV1), .buck_level_second_i(LV2), .reg_rdata_o(reg_rdata),
    .reg_rvalid_o(reg_rvalid), .buck_on_o(buck_on), .linreg_on_o(linreg_on),
    .buck_level_o(level), .buck_discharge_on_o(buck_dis),
    .linreg_discharge_on_o(linreg_dis), .thermal_halt_o(halt)
  );

  pmrcs_host_model u_host (
    .clk_i(clk_i), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid),
    .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd)
  );

  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    cmp(d, exp);
  endtask : rdc

  task automatic do_reset();
    resetn_i = 1'b0;
    cyc(5);
    resetn_i = 1'b1;
    cyc(4);
  endtask : do_reset

  task automatic t_defaults();
    rdc(PMRCS_OFS_RAIL_ENABLE, PMRCS_RST_RAIL_ENABLE);
    rdc(PMRCS_OFS_DISCHARGE, PMRCS_RST_DISCHARGE);
    rdc(PMRCS_OFS_SENSE, PMRCS_RST_SENSE);
    rdc(PMRCS_OFS_ACK, PMRCS_RST_ACK);
    rdc(8'h20, 8'h00);
    cmp(dis, 8'h3f);
    cmp(rail, 8'h00);
    cmp({3'b000, level}, {3'b000, LV1});
  endtask : t_defaults

  task automatic t_powerup();
    pin = 1'b1;
    cyc(8);
    rdc(PMRCS_OFS_ACK, 8'h00);
    cyc(PWR_CYC - 20);
    rdc(PMRCS_OFS_SENSE, 8'h00);
    cyc(16);
    rdc(PMRCS_OFS_SENSE, 8'h04);
    rdc(PMRCS_OFS_ACK, 8'h04);
    rdc(PMRCS_OFS_ACK, 8'h00);
    u_host.wr(PMRCS_OFS_RAIL_ENABLE, 8'hbf);
    cyc(3);
    cmp(rail, 8'h9f);
    cmp({3'b000, level}, {3'b000, LV1});
    u_host.wr(PMRCS_OFS_RAIL_ENABLE, 8'h35);
    cyc(3);
    cmp(rail, 8'h95);
    cmp({3'b000, level}, {3'b000, LV2});
    u_host.wr(PMRCS_OFS_DISCHARGE, 8'h0a);
    cyc(3);
    cmp(dis, 8'h0a);
    u_host.wr(PMRCS_OFS_SENSE, 8'hff);
    rdc(PMRCS_OFS_SENSE, 8'h04);
  endtask : t_powerup

  task automatic t_flags();
    uv   = 1'b1;
    warn = 1'b1;
    cyc(6);
    rdc(PMRCS_OFS_SENSE, 8'h0d);
    rdc(PMRCS_OFS_ACK, 8'h09);
    uv   = 1'b0;
    warn = 1'b0;
    cyc(6);
    rdc(PMRCS_OFS_SENSE, 8'h04);
    rdc(PMRCS_OFS_ACK, 8'h09);
    rdc(PMRCS_OFS_ACK, 8'h00);
  endtask : t_flags

  // recovery codes in the order 01, 00, 11, 10
  task automatic t_thermal();
    logic [1:0] p;
    for (int i = 0; i < 4; i++)
    begin
      p = 2'(i ^ 1);
      u_host.wr(PMRCS_OFS_RAIL_ENABLE, 8'hb0);
      u_host.wr(PMRCS_OFS_DISCHARGE, {p, 6'h3f});
      tsd = 1'b1;
      cyc(10);
      rdc(PMRCS_OFS_SENSE, 8'h06);
      cmp({7'h00, halt}, 8'h01);
      cmp(rail, 8'h00);
      tsd = 1'b0;
      cyc(PWR_CYC + 16);
      cmp({7'h00, halt}, {7'h00, p[1]});
      cmp(rail, p == 2'b01 ? 8'h90 : 8'h00);
      rdc(PMRCS_OFS_RAIL_ENABLE, p == 2'b00 ? 8'h80 : 8'hb0);
      rdc(PMRCS_OFS_ACK, p[1] ? 8'h02 : 8'h06);
      if (p[1])
      begin
        pin = 1'b0;
        cyc(6);
        rdc(PMRCS_OFS_SENSE, 8'h04);
        pin = 1'b1;
        cyc(PWR_CYC + 16);
        cmp({7'h00, halt}, 8'h00);
        rdc(PMRCS_OFS_ACK, 8'h04);
      end
    end
  endtask : t_thermal

  initial
  begin
    #100us;
    miscompares++;
    final_report();
  end

  initial
  begin
    do_reset();
    t_defaults();
    t_powerup();
    t_flags();
    t_thermal();
    pin = 1'b0;
    u_host.wr(PMRCS_OFS_RAIL_ENABLE, 8'h3f);
    do_reset();
    t_defaults();
    final_report();
  end
endmodule : tb_pmrcs_regs
